// ==== design/sfpi_top.sv ====
// Serial flash pin interface: shifts bytes in and out against the master's
// serial clock and reports frame, pause and protection state to the core.
// Assumes the serial pins are synchronous to sck, and that the core logic on
// clk consumes received bytes and supplies reply bytes.
`default_nettype none
`include "sfpi_defs.svh"

module sfpi_top
  import sfpi_pkg::*;
#(
  parameter int BYTE_W    = `SFPI_BYTE_W,
  parameter int BUF_DEPTH = `SFPI_BUF_DEPTH
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                sck,
  input  wire logic                cs_n,
  input  wire logic                si,
  output logic                     so,
  output logic                     so_oe,
  input  wire logic                pause_n,
  input  wire logic                wp_n,
  input  wire logic [2:0]          block_protect_bits,
  input  wire sfpi_op_t            op,
  output logic                     op_blocked,
  input  wire logic                busy,
  output logic                     rx_valid,
  input  wire logic                rx_ready,
  output sfpi_rx_t                 rx_data,
  input  wire logic                tx_valid,
  output logic                     tx_ready,
  input  wire logic [BYTE_W-1:0]   tx_data,
  output logic                     selected,
  output logic                     active,
  output logic                     standby,
  output logic                     paused,
  output logic                     overrun
);

  // The shift logic and the byte struct are built for eight-bit bytes only
  initial begin
    if (BYTE_W != `SFPI_BYTE_W) begin
      $error("sfpi_top: BYTE_W must be 8");
    end
    if (BUF_DEPTH != `SFPI_BUF_DEPTH) begin
      $error("sfpi_top: BUF_DEPTH must be 2");
    end
  end

  // Sector protection decode; top sectors are protected first
  function automatic logic prot_hit(input logic [2:0] bp,
                                    input logic [4:0] sector);
    logic [5:0] lowest;
    lowest = 6'h00;
    if (bp >= `SFPI_BP_ALL) begin
      prot_hit = 1'b1;
    end else if (bp == `SFPI_BP_NONE) begin
      prot_hit = 1'b0;
    end else begin
      lowest   = `SFPI_SECT_COUNT - (6'h01 << (bp - 3'h1));
      prot_hit = {1'b0, sector} >= lowest;
    end
  endfunction

  // ------------------------------------------------------------------
  // Link side, clocked by the master's serial clock
  // ------------------------------------------------------------------

  // Deselection resets the frame state; the frame starts clean each time
  wire sck_rst_n = rst_n & ~cs_n;

  logic [2:0]         rx_cnt_r;
  logic [6:0]         rx_sh_r;
  logic               first_r;
  logic               rx_tgl_r;
  logic               mid_tgl_r;
  sfpi_rx_t           rx_word_r;
  logic [BYTE_W-1:0]  tx_sh_r;
  logic               so_r;
  logic               hold_q_r;
  logic [BYTE_W-1:0]  tx_next_r;

  // Pause gating: the clock edge is ignored while the pause pin is low
  wire                take      = pause_n;
  wire                byte_end  = rx_cnt_r == `SFPI_LAST_BIT;
  wire                mid_byte  = rx_cnt_r == `SFPI_MID_BIT;
  wire [2:0]          rx_cnt_nxt = take ? rx_cnt_r + 3'h1 : rx_cnt_r;
  wire [6:0]          rx_sh_nxt  = take ? {rx_sh_r[5:0], si} : rx_sh_r;
  wire                first_nxt  = first_r & ~(take & byte_end);
  wire sfpi_rx_t      rx_word_nxt = '{first: first_r, data: {rx_sh_r, si}};

  // Bit counter and input shifter, MSB enters first
  always_ff @(posedge sck or negedge sck_rst_n) begin
    if (!sck_rst_n) begin
      rx_cnt_r <= 3'h0;
      rx_sh_r  <= 7'h00;
      first_r  <= 1'b1;
    end else begin
      rx_cnt_r <= rx_cnt_nxt;
      rx_sh_r  <= rx_sh_nxt;
      first_r  <= first_nxt;
    end
  end

  // Toggles survive deselection, otherwise the far side would see a
  // spurious event every time chip select rises
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rx_tgl_r  <= 1'b0;
      mid_tgl_r <= 1'b0;
      rx_word_r <= '0;
    end else begin
      rx_tgl_r  <= rx_tgl_r ^ (take & byte_end);
      mid_tgl_r <= mid_tgl_r ^ (take & mid_byte);
      rx_word_r <= (take & byte_end) ? rx_word_nxt : rx_word_r;
    end
  end

  // Output side: a new reply byte is taken at the first falling edge of
  // each byte after the first; the first byte always returns the fill
  wire                load_tx  = (rx_cnt_r == 3'h0) & ~first_r;
  wire [BYTE_W-1:0]   tx_sh_nxt = load_tx ? tx_next_r : tx_sh_r;
  wire                so_nxt    = load_tx ? tx_next_r[BYTE_W-1] : tx_sh_r[~rx_cnt_r];

  // Output bit changes only on the falling edge
  always_ff @(negedge sck or negedge sck_rst_n) begin
    if (!sck_rst_n) begin
      tx_sh_r  <= `SFPI_IDLE_FILL;
      so_r     <= 1'b1;
      hold_q_r <= 1'b0;
    end else begin
      tx_sh_r  <= take ? tx_sh_nxt : tx_sh_r;
      so_r     <= take ? so_nxt : so_r;
      hold_q_r <= ~pause_n;
    end
  end

  // While the clock is low the pause follows the pin; with the clock high
  // it waits for the next falling edge
  wire hold_eff = sck ? hold_q_r : ~pause_n;
  assign so    = so_r;
  assign so_oe = ~cs_n & ~hold_eff;

  // ------------------------------------------------------------------
  // Core side, clocked by clk
  // ------------------------------------------------------------------

  // Two-flop synchronisers for chip select, pause, protect and toggles
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  wire  [4:0] async_in = {mid_tgl_r, rx_tgl_r, wp_n, pause_n, cs_n};

  localparam logic [4:0] SYNC_RST = `SFPI_SYNC_RST;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[gi] <= SYNC_RST[gi];
          sync_r[gi] <= SYNC_RST[gi];
        end else begin
          meta_r[gi] <= async_in[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  wire cs_s    = sync_r[0];
  wire pause_s = sync_r[1];
  wire wp_s    = sync_r[2];

  logic       cs_d_r;
  logic       rx_d_r;
  logic       mid_d_r;
  logic [2:0] live_r;
  sfpi_arm_t  arm_r;
  sfpi_arm_t  arm_nxt;

  // Edge detectors only look at synchronised copies
  wire rx_evt  = sync_r[3] ^ rx_d_r;
  wire mid_evt = sync_r[4] ^ mid_d_r;
  // A low level already present at reset release is not an edge: the
  // delayed copy holds the pin's level only from the third edge on
  wire cs_fall = live_r[2] & cs_d_r & ~cs_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_d_r  <= 1'b1;
      rx_d_r  <= 1'b0;
      mid_d_r <= 1'b0;
      live_r  <= 3'h0;
    end else begin
      cs_d_r  <= cs_s;
      rx_d_r  <= sync_r[3];
      mid_d_r <= sync_r[4];
      live_r  <= {live_r[1:0], 1'b1};
    end
  end

  // Arming: bytes are dropped until a chip select fall has been seen
  always_comb begin
    arm_nxt = arm_r;
    unique case (arm_r)
      SFPI_ARM_WAIT: arm_nxt = cs_fall ? SFPI_ARM_LIVE : SFPI_ARM_WAIT;
      SFPI_ARM_LIVE: arm_nxt = SFPI_ARM_LIVE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_r <= SFPI_ARM_WAIT;
    end else begin
      arm_r <= arm_nxt;
    end
  end

  // Received bytes go through the two-entry buffer; rx_word_r is stable
  // for a whole byte time after its toggle, so it is read directly
  wire buf_in_ready;
  wire rx_push = rx_evt & (arm_r == SFPI_ARM_LIVE);

  sfpi_buf #(
    .W     ($bits(sfpi_rx_t)),
    .DEPTH (BUF_DEPTH)
  ) u_rx_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (rx_push),
    .in_ready  (buf_in_ready),
    .in_data   (rx_word_r),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // Reply path: one pending byte; handed over at mid-byte so it is steady
  // long before the link loads it at the next byte boundary
  logic [BYTE_W-1:0] pend_r;
  logic              pend_v_r;
  wire               tx_take = tx_valid & ~pend_v_r;
  assign tx_ready = ~pend_v_r;

  wire [BYTE_W-1:0] tx_next_nxt = mid_evt ? (pend_v_r ? pend_r : `SFPI_IDLE_FILL)
                                          : tx_next_r;
  wire              pend_v_nxt  = tx_take | (pend_v_r & ~mid_evt);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r    <= `SFPI_IDLE_FILL;
      pend_v_r  <= 1'b0;
      tx_next_r <= `SFPI_IDLE_FILL;
    end else begin
      pend_r    <= tx_take ? tx_data : pend_r;
      pend_v_r  <= pend_v_nxt;
      tx_next_r <= tx_next_nxt;
    end
  end

  // Status; the overrun flag set wins over its clear at a new frame
  logic selected_r;
  logic active_r;
  logic standby_r;
  logic paused_r;
  logic overrun_r;
  logic op_blocked_r;

  wire ovr_set    = rx_push & ~buf_in_ready;
  wire op_hit     = prot_hit(block_protect_bits,
                             op.addr[`SFPI_SECT_MSB:`SFPI_SECT_LSB]);
  wire blocked_nxt = op.check & ~wp_s & op_hit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selected_r   <= 1'b0;
      active_r     <= 1'b0;
      standby_r    <= 1'b1;
      paused_r     <= 1'b0;
      overrun_r    <= 1'b0;
      op_blocked_r <= 1'b0;
    end else begin
      selected_r   <= ~cs_s;
      active_r     <= ~cs_s & (arm_r == SFPI_ARM_LIVE);
      standby_r    <= cs_s & ~busy;
      paused_r     <= ~cs_s & ~pause_s;
      overrun_r    <= ovr_set | (overrun_r & ~cs_fall);
      op_blocked_r <= blocked_nxt;
    end
  end

  assign selected   = selected_r;
  assign active     = active_r;
  assign standby    = standby_r;
  assign paused     = paused_r;
  assign overrun    = overrun_r;
  assign op_blocked = op_blocked_r;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------

  AST_DESEL_HIZ: assert property (@(posedge clk) disable iff (!rst_n)
    cs_n |-> !so_oe)
    else $error("output driven while deselected");

  AST_PAUSE_HIZ: assert property (@(posedge clk) disable iff (!rst_n)
    (!pause_n && !sck) |-> !so_oe)
    else $error("output driven while paused");

  AST_NO_PUSH_UNARMED: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_evt && arm_r == SFPI_ARM_WAIT) |=> $stable(u_rx_buf.cnt_r) || $fell(rx_valid)
      || (rx_ready && rx_valid))
    else $error("byte accepted before the first select edge");

  AST_ARM_AFTER_FALL: assert property (@(posedge clk) disable iff (!rst_n)
    cs_fall |=> (arm_r == SFPI_ARM_LIVE) ##1 active)
    else $error("not armed after select fall");

  AST_STANDBY: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_s && !busy) ##1 (cs_s && !busy) |=> standby && !active && !selected)
    else $error("standby not shown while idle");

  AST_ACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
    (!cs_s && arm_r == SFPI_ARM_LIVE) |=> active && !standby)
    else $error("active not shown while selected");

  AST_WP_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    (op.check && !wp_s && op_hit) |=> op_blocked)
    else $error("protected operation not blocked");

  AST_WP_FREE: assert property (@(posedge clk) disable iff (!rst_n)
    (wp_s || !op_hit) |=> !op_blocked)
    else $error("operation blocked outside protection");

  AST_PAUSE_FREEZE: assert property (@(posedge sck) disable iff (!sck_rst_n)
    !pause_n |=> rx_cnt_r == $past(rx_cnt_r) && rx_sh_r == $past(rx_sh_r))
    else $error("bit state moved while paused");

  AST_SAMPLE_RISE: assert property (@(posedge sck) disable iff (!sck_rst_n)
    (pause_n && !byte_end) |=> rx_sh_r[0] == $past(si))
    else $error("input bit not sampled on rising edge");

  AST_BYTE_EIGHT: assert property (@(posedge sck) disable iff (!sck_rst_n)
    (pause_n && byte_end) |=> rx_cnt_r == 3'h0 && rx_tgl_r != $past(rx_tgl_r))
    else $error("byte boundary not after eight bits");

endmodule

`default_nettype wire

// ==== include/sfpi_defs.svh ====
// Constants for the serial flash pin interface: bit positions, fill values
// and reset values. Assumes inclusion by the package and by the modules.
//
// Notes on behaviour
// - Each outgoing bit is placed on the serial output at a falling serial clock edge.
// - Command, address and data bits are sampled from the serial input at rising edges.
// - With chip select high the device is deselected and its output is high impedance.
// - With chip select low the device is active and takes part in communication.
// - Commands are ignored until a falling chip select edge has been seen after power-up.
// - Standby holds whenever the device is deselected and no write operation is busy.
// - Pausing freezes the serial exchange without deselection so it resumes where it stopped.
// - While paused the output is high impedance and serial input and clock are ignored.
// - With write protect low, program and erase inside the protected area are blocked.
// - Clock modes with polarity and phase both zero or both one are both served.
// - All traffic is grouped into whole bytes of eight bits in both directions.
`ifndef SFPI_DEFS_SVH
`define SFPI_DEFS_SVH

`define SFPI_BYTE_W      8
`define SFPI_LAST_BIT    3'h7
`define SFPI_MID_BIT     3'h3
`define SFPI_IDLE_FILL   8'hFF
`define SFPI_ADDR_W      21
`define SFPI_SECT_MSB    20
`define SFPI_SECT_LSB    16
`define SFPI_BP_NONE     3'h0
`define SFPI_BP_ALL      3'h6
`define SFPI_SECT_COUNT  6'h20
`define SFPI_SYNC_RST    5'h07
`define SFPI_BUF_DEPTH   2

`endif

// ==== include/sfpi_pkg.sv ====
// Types shared by the serial flash pin interface modules.
// Assumes sfpi_defs.svh is on the include path.
`default_nettype none
`include "sfpi_defs.svh"

package sfpi_pkg;

  // One received byte and whether it opened the frame
  typedef struct packed {
    logic                      first;
    logic [`SFPI_BYTE_W-1:0]   data;
  } sfpi_rx_t;

  // Program or erase check presented by the command logic
  typedef struct packed {
    logic                      check;
    logic [`SFPI_ADDR_W-1:0]   addr;
  } sfpi_op_t;

  // Power-up arming of the command path
  typedef enum logic {
    SFPI_ARM_WAIT = 1'b0,
    SFPI_ARM_LIVE = 1'b1
  } sfpi_arm_t;

endpackage

`default_nettype wire

// ==== design/sfpi_buf.sv ====
// Small ring buffer with valid and ready on both sides.
// Assumes a single clock; both sides are synchronous to it.
`default_nettype none

module sfpi_buf #(
  parameter int W     = 9,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin
      $error("sfpi_buf: DEPTH must be a power of two of at least 2");
    end
  end

  logic [W-1:0]  mem_r [DEPTH];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] rd_r;
  logic [PW:0]   cnt_r;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  // Full and empty come straight from the occupancy count
  assign in_ready  = cnt_r != (PW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem_r[rd_r];

  // Storage is written only on an accepted push
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= push ? wr_r + PW'(1) : wr_r;
      rd_r  <= pop ? rd_r + PW'(1) : rd_r;
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// ==== testbench/sfpi_master.sv ====
// SPI master model: frames, whole or cut bytes, and a pause in mid-byte.
// Assumes the bench calls its tasks and hands it so as a tristated wire.
`default_nettype none

module sfpi_master (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      pause_n,
  input  wire logic so_w
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 24;

  // Idle pins; the clock stands still outside frames
  initial begin
    sck     = 1'h0;
    cs_n    = 1'h1;
    si      = 1'h0;
    pause_n = 1'h1;
  end

  // Idle level of sck before the select edge picks mode 0 or mode 3
  task automatic sel(input logic m3);
    sck = m3;
    #HALF cs_n = 1'h0;
    #HALF;
  endtask

  task automatic desel();
    #HALF cs_n = 1'h1;
    si = ~si;
    #HALF;
  endtask

  // Pause with sck low; junk on si and sck meanwhile, cs_n stays low
  task automatic pause_mid();
    #HALF pause_n = 1'h0;
    repeat (4) begin
      si = ~si;
      #HALF sck = ~sck;
    end
    #HALF pause_n = 1'h1;
    #HALF;
  endtask

  // Data set on the fall, both sides sampled on the rise
  task automatic xfer(input logic m3, input logic [7:0] tx, input int nbits,
                      input int pause_at, output logic [7:0] rx);
    rx = 8'hFF;
    for (int i = 0; i < nbits; i++) begin
      if (i == pause_at) pause_mid();
      if (m3) sck = 1'h0;
      si = tx[7-i];
      #HALF sck = 1'h1;
      rx[7-i] = so_w;
      #HALF if (!m3) sck = 1'h0;
    end
    si = ~si; // Released data line does not keep its last value
  endtask
endmodule

`default_nettype wire

// ==== testbench/sfpi_top_bench.sv ====
// Bench for the serial flash pin interface: master model on the pins and a
// core stand-in on clk. Assumes the design package and header are compiled.
`default_nettype none

module sfpi_top_bench
  import sfpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk, rst_n, wp_n, busy, rx_ready, tx_valid;
  logic [2:0] block_protect_bits;
  logic [7:0] tx_data;
  sfpi_op_t   op;
  sfpi_rx_t   rx_data;
  logic       so, so_oe, op_blocked, rx_valid, tx_ready;
  logic       selected, active, standby, paused, overrun;
  wire logic  sck, cs_n, si, pause_n, so_w;
  sfpi_rx_t   rxq[$];
  int         failures = 0;
  int         num_checks = 0;

  sfpi_top uut (
    .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .pause_n(pause_n), .wp_n(wp_n),
    .block_protect_bits(block_protect_bits), .op(op), .op_blocked(op_blocked),
    .busy(busy), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .selected(selected), .active(active), .standby(standby), .paused(paused),
    .overrun(overrun)
  );

  // No pull on the data line, so an undriven so reads as high impedance
  assign so_w = so_oe ? so : 1'hz;

  sfpi_master m (.sck(sck), .cs_n(cs_n), .si(si), .pause_n(pause_n), .so_w(so_w));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Core side: every byte taken by a handshake lands in the queue
  always @(posedge clk) begin
    if (rx_valid === 1'h1 && rx_ready === 1'h1) rxq.push_back(rx_data);
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Offer one reply byte; it is refused again until consumed at mid-byte
  task automatic tx_push(input logic [7:0] b);
    cyc(1);
    chk(tx_ready, 1'h1, "tx_ready before offer");
    tx_valid = 1'h1;
    tx_data  = b;
    cyc(1);
    tx_valid = 1'h0;
    chk(tx_ready, 1'h0, "tx_ready after take");
  endtask

  // Protected sectors: none, the top 2^(code-1) sectors, or all of them
  function automatic logic prot(input logic [2:0] code, input logic [4:0] sec);
    if (code == 3'h0) return 1'h0;
    if (code >= 3'h6) return 1'h1;
    return sec >= 5'(32 - (1 << (code - 1)));
  endfunction

  // cs_n already low at reset release must not arm the command path
  task automatic t_unarmed();
    logic [7:0] r;
    chk(rx_valid, 1'h0, "rx_valid after reset");
    chk(tx_ready, 1'h1, "tx_ready after reset");
    chk(overrun, 1'h0, "overrun after reset");
    cyc(6);
    m.xfer(1'h0, 8'h9F, 8, 99, r);
    cyc(8);
    chk(selected, 1'h1, "selected");
    chk(active, 1'h0, "active before arming");
    chk(9'(rxq.size()), 9'h000, "bytes before arming");
    m.desel();
    cyc(6);
    chk(so_oe, 1'h0, "so released");
    chk(standby, 1'h1, "standby when idle");
    busy = 1'h1;
    cyc(4);
    chk(standby, 1'h0, "standby while busy");
    busy = 1'h0;
    cyc(4);
    chk(standby, 1'h1, "standby after busy");
    $display("test unarmed done");
  endtask

  // Two-byte frame: reply byte 0 is fill, byte 1 is the byte offered before
  task automatic t_frame(input logic m3, input logic [7:0] b0, b1, rep);
    logic [7:0] r;
    rxq.delete();
    tx_push(rep);
    m.sel(m3);
    cyc(3);
    chk(active, 1'h1, "active");
    chk(standby, 1'h0, "standby while selected");
    chk(so_oe, 1'h1, "so driven");
    m.xfer(m3, b0, 8, 99, r);
    chk(r, 8'hFF, "reply byte 0");
    m.xfer(m3, b1, 8, 99, r);
    chk(r, rep, "reply byte 1");
    m.desel();
    cyc(8);
    chk(so_oe, 1'h0, "so released");
    chk(9'(rxq.size()), 9'h002, "rx count");
    chk(rxq[0], {1'h1, b0}, "rx byte 0");
    chk(rxq[1], {1'h0, b1}, "rx byte 1");
    $display("test frame mode %0d done", m3);
  endtask

  // A byte cut short by deselection is dropped; the next frame is clean
  task automatic t_partial();
    logic [7:0] r;
    rxq.delete();
    m.sel(1'h0);
    m.xfer(1'h0, 8'hF0, 5, 99, r);
    m.desel();
    m.sel(1'h0);
    m.xfer(1'h0, 8'h66, 8, 99, r);
    chk(r, 8'hFF, "reply after cut frame");
    m.desel();
    cyc(8);
    chk(9'(rxq.size()), 9'h001, "only whole bytes");
    chk(rxq[0], {1'h1, 8'h66}, "byte after cut");
    $display("test partial done");
  endtask

  // Pause after three bits; junk clocks during the pause must not shift
  task automatic t_pause();
    logic [7:0] r;
    rxq.delete();
    tx_push(8'h3C);
    m.sel(1'h0);
    m.xfer(1'h0, 8'h11, 8, 99, r);
    fork
      m.xfer(1'h0, 8'hB6, 8, 3, r);
      begin
        @(negedge pause_n);
        #60;
        chk(paused, 1'h1, "paused flag");
        chk(selected, 1'h1, "selected in pause");
        chk(so_oe, 1'h0, "so released in pause");
      end
    join
    chk(r, 8'h3C, "reply across pause");
    m.desel();
    cyc(8);
    chk(rxq[1], {1'h0, 8'hB6}, "byte across pause");
    $display("test pause done");
  endtask

  // Core stalls: two bytes fit, the third is lost and flagged, then drain
  task automatic t_overrun();
    logic [7:0] r;
    rxq.delete();
    rx_ready = 1'h0;
    m.sel(1'h0);
    m.xfer(1'h0, 8'hA1, 8, 99, r);
    m.xfer(1'h0, 8'hA2, 8, 99, r);
    m.xfer(1'h0, 8'hA3, 8, 99, r);
    m.desel();
    cyc(8);
    chk(overrun, 1'h1, "overrun flagged");
    chk(rx_data, {1'h1, 8'hA1}, "oldest byte held");
    rx_ready = 1'h1;
    cyc(4);
    chk(9'(rxq.size()), 9'h002, "drained count");
    chk(rxq[1], {1'h0, 8'hA2}, "second byte kept");
    chk(rx_valid, 1'h0, "buffer empty");
    m.sel(1'h0);
    cyc(4);
    chk(overrun, 1'h0, "overrun cleared by select");
    m.desel();
    $display("test overrun done");
  endtask

  // Every protect code against top, boundary and bottom sectors, wp both ways
  task automatic t_protect();
    logic [20:0] addrs [4] = '{21'h1F0000, 21'h100000, 21'h0FFFFF, 21'h000000};
    for (int w = 0; w < 2; w++) begin
      wp_n = w[0];
      for (int b = 0; b < 8; b++) begin
        block_protect_bits = b[2:0];
        cyc(4);
        for (int a = 0; a < 4; a++) begin
          op = '{check: 1'h1, addr: addrs[a]};
          cyc(1);
          chk(op_blocked, !w[0] && prot(b[2:0], addrs[a][20:16]), "op blocked");
        end
        op.check = 1'h0;
        cyc(1);
        chk(op_blocked, 1'h0, "no check asked");
      end
    end
    $display("test protect done");
  endtask

  // Reset in mid-run with chip select high: state clears, arming starts over
  task automatic t_reset();
    tx_push(8'h99);
    busy = 1'h1;
    cyc(2);
    chk(standby, 1'h0, "standby while busy");
    rst_n = 1'h0;
    cyc(2);
    chk(tx_ready, 1'h1, "tx_ready in reset");
    chk(standby, 1'h1, "standby in reset");
    chk(active, 1'h0, "active in reset");
    rst_n = 1'h1;
    busy  = 1'h0;
    cyc(6);
    chk(active, 1'h0, "unarmed after reset");
    m.sel(1'h0);
    cyc(4);
    chk(active, 1'h1, "armed by select fall");
    m.desel();
    cyc(4);
    $display("test reset done");
  endtask

  // Watchdog well beyond the eight or so microseconds the tests need
  initial begin
    #200000;
    failures++;
    results();
  end

  initial begin
    rst_n              = 1'h0;
    wp_n               = 1'h1;
    block_protect_bits = 3'h0;
    op                 = '0;
    busy               = 1'h0;
    rx_ready           = 1'h1;
    tx_valid           = 1'h0;
    tx_data            = 8'h00;
    m.sel(1'h0);
    repeat (8) @(posedge clk);
    #1 rst_n = 1'h1;
    t_unarmed();
    t_frame(1'h0, 8'h3C, 8'h81, 8'hA5);
    t_frame(1'h1, 8'hC3, 8'h7E, 8'h5A);
    t_partial();
    t_pause();
    t_overrun();
    t_reset();
    t_protect();
    results();
  end
endmodule

`default_nettype wire
